// >>> ipsel_top.sv
// Multi-function pin selector: indicators, interrupt, wake event, ref clock
// How it works
// - The second indicator pin shows activity, speed, interrupt or wake event per its select field.
// - The first indicator pin does the same per its own select field.
// - The interrupt output is driven low while an interrupt is pending and high otherwise.
// - The shared pin carries the interrupt unless an indicator pin is set to carry it.
// - The wake event output is driven low on an event and may also appear on an indicator pin.
// - A high or floating strap makes the shared pin the interrupt, a low strap the ref clock.
// - The strap is sampled throughout every power-on or system reset and held after release.
// - A low level on the external reset pin is a system reset.
// - In ref clock mode the shared pin carries a 50 MHz clock divided from the main clock.
`timescale 1ns/1ps
`default_nettype none
`include "ipsel_defines.svh"
module ipsel_top
  import ipsel_pkg::*;
#(
  parameter int unsigned REF_HALF_CYC = `IPSEL_REF_HALF_CYC
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic ext_reset_n,
  input wire logic irq_or_clock_pin_strap,
  input wire logic link_activity,
  input wire logic link_speed,
  input wire logic irq_pending,
  input wire logic wake_event,
  input wire logic [`IPSEL_FSEL_W-1:0] first_pin_fsel,
  input wire logic [`IPSEL_FSEL_W-1:0] second_pin_fsel,
  output logic first_indicator_pin,
  output logic second_indicator_pin,
  output logic irq_n_out,
  output logic wake_event_n_out,
  output logic shared_pin_o,
  output logic shared_pin_oe,
  output logic strap_irq_mode,
  output logic sys_reset_active
);

  // Pin synchronisers
  logic [1:0] rst_sync_q;
  logic [1:0] rst_sync_d;
  logic [1:0] strap_sync_q;
  logic [1:0] strap_sync_d;

  always_comb begin
    rst_sync_d = rst_sync_q;
    strap_sync_d = strap_sync_q;
    if (clk_en) begin
      rst_sync_d = {rst_sync_q[0], ext_reset_n};
      strap_sync_d = {strap_sync_q[0], irq_or_clock_pin_strap};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rst_sync_q <= `IPSEL_RST_SYNC;
    end else begin
      rst_sync_q <= rst_sync_d;
    end
    // Strap sync runs through reset so the latch sees the pin
    strap_sync_q <= strap_sync_d;
  end

  logic sys_rst;
  assign sys_rst = srst | ~rst_sync_q[1];
  assign sys_reset_active = sys_rst;

  // Strap latch
  logic strap_q;
  logic strap_d;

  always_comb begin
    strap_d = strap_q;
    if (clk_en && sys_rst) begin
      strap_d = strap_sync_q[1];
    end
  end

  always_ff @(posedge clock) begin
    strap_q <= strap_d;
  end

  assign strap_irq_mode = (strap_q == `IPSEL_STRAP_IRQ);

  // Indicator pins
  ipsel_ind_if ind1 ();
  ipsel_ind_if ind2 ();

  assign ind1.sel = ipsel_fn_t'(first_pin_fsel);
  assign ind2.sel = ipsel_fn_t'(second_pin_fsel);
  assign ind1.act = link_activity;
  assign ind2.act = link_activity;
  assign ind1.spd = link_speed;
  assign ind2.spd = link_speed;
  assign ind1.irq_n = ~irq_pending;
  assign ind2.irq_n = ~irq_pending;
  assign ind1.wake_n = ~wake_event;
  assign ind2.wake_n = ~wake_event;

  ipsel_ind_mux u_first (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .ind(ind1)
  );

  ipsel_ind_mux u_second (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .ind(ind2)
  );

  assign first_indicator_pin = ind1.pin;
  assign second_indicator_pin = ind2.pin;

  // Interrupt, wake event and shared pin
  logic irq_n_q;
  logic irq_n_d;
  logic wake_n_q;
  logic wake_n_d;
  logic sh_o_q;
  logic sh_o_d;
  logic sh_oe_q;
  logic sh_oe_d;
  logic refclk_q;
  logic refclk_d;
  logic [`IPSEL_REF_CNT_W-1:0] ref_cnt_q;
  logic [`IPSEL_REF_CNT_W-1:0] ref_cnt_d;
  logic irq_rerouted;
  logic ref_wrap;

  assign irq_rerouted = (ind1.sel == IPSEL_FN_IRQ) || (ind2.sel == IPSEL_FN_IRQ);
  assign ref_wrap = (ref_cnt_q == `IPSEL_REF_CNT_W'(REF_HALF_CYC - 1));

  always_comb begin
    irq_n_d = irq_n_q;
    wake_n_d = wake_n_q;
    refclk_d = refclk_q;
    ref_cnt_d = ref_cnt_q;
    sh_o_d = sh_o_q;
    sh_oe_d = sh_oe_q;
    if (clk_en) begin
      irq_n_d = ~irq_pending;
      wake_n_d = ~wake_event;
      if (ref_wrap) begin
        ref_cnt_d = '0;
        refclk_d = ~refclk_q;
      end else begin
        ref_cnt_d = ref_cnt_q + `IPSEL_REF_CNT_W'(1);
      end
      if (strap_irq_mode) begin
        sh_o_d = 1'b0;
        sh_oe_d = irq_pending && !irq_rerouted;
      end else begin
        sh_o_d = refclk_d;
        sh_oe_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_n_q <= `IPSEL_RST_IRQ_N;
      wake_n_q <= `IPSEL_RST_IRQ_N;
      refclk_q <= 1'b0;
      ref_cnt_q <= '0;
      sh_o_q <= 1'b0;
      sh_oe_q <= 1'b0;
    end else begin
      irq_n_q <= irq_n_d;
      wake_n_q <= wake_n_d;
      refclk_q <= refclk_d;
      ref_cnt_q <= ref_cnt_d;
      sh_o_q <= sh_o_d;
      sh_oe_q <= sh_oe_d;
    end
  end

  assign irq_n_out = irq_n_q;
  assign wake_event_n_out = wake_n_q;
  assign shared_pin_o = sh_o_q;
  assign shared_pin_oe = sh_oe_q;

  // Checks
  logic run;
  assign run = clk_en && !sys_rst;

  AST_SECOND_IRQ: assert property (@(posedge clock) disable iff (sys_rst)
    (run && ind2.sel == IPSEL_FN_IRQ) |=> (second_indicator_pin == !$past(irq_pending)))
    else $error("second indicator does not follow interrupt");

  AST_SECOND_ACT: assert property (@(posedge clock) disable iff (sys_rst)
    (run && ind2.sel == IPSEL_FN_ACTIVITY) |=> (second_indicator_pin == $past(link_activity)))
    else $error("second indicator does not follow activity");

  AST_FIRST_SPD: assert property (@(posedge clock) disable iff (sys_rst)
    (run && ind1.sel == IPSEL_FN_SPEED) |=> (first_indicator_pin == $past(link_speed)))
    else $error("first indicator does not follow speed");

  AST_FIRST_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
    (run && ind1.sel == IPSEL_FN_WAKE) |=> (first_indicator_pin == !$past(wake_event)))
    else $error("first indicator does not follow wake event");

  AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (sys_rst)
    run |=> (irq_n_out == !$past(irq_pending)))
    else $error("interrupt output level wrong");

  AST_WAKE_LEVEL: assert property (@(posedge clock) disable iff (sys_rst)
    run |=> (wake_event_n_out == !$past(wake_event)))
    else $error("wake event output level wrong");

  AST_SHARED_IRQ: assert property (@(posedge clock) disable iff (sys_rst)
    (run && strap_irq_mode && irq_pending && !irq_rerouted) |=> (shared_pin_oe && !shared_pin_o))
    else $error("shared pin does not pull low for interrupt");

  AST_SHARED_ROUTED: assert property (@(posedge clock) disable iff (sys_rst)
    (run && strap_irq_mode && irq_rerouted) |=> !shared_pin_oe)
    else $error("shared pin driven while interrupt rerouted");

  AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (sys_rst)
    strap_irq_mode |-> !(shared_pin_oe && shared_pin_o))
    else $error("shared pin driven high in interrupt mode");

  AST_CLK_MODE: assert property (@(posedge clock) disable iff (sys_rst)
    (run && !strap_irq_mode) |=> shared_pin_oe)
    else $error("shared pin not driven in clock mode");

  AST_REF_TOGGLE: assert property (@(posedge clock) disable iff (sys_rst)
    (run && !strap_irq_mode && ref_wrap) |=> (shared_pin_o != $past(shared_pin_o)))
    else $error("reference clock does not toggle");

  AST_STRAP_HOLD: assert property (@(posedge clock) disable iff (srst)
    (!sys_rst ##1 !sys_rst) |-> $stable(strap_q))
    else $error("strap changed outside reset");

  AST_EXT_RST: assert property (@(posedge clock) disable iff (srst)
    (!rst_sync_q[1]) |=> (irq_n_out && wake_event_n_out && !shared_pin_oe))
    else $error("external reset did not reset outputs");

  COV_IRQ_SHARED: cover property (@(posedge clock) run && strap_irq_mode && shared_pin_oe);
  COV_REF_MODE: cover property (@(posedge clock) run && !strap_irq_mode && shared_pin_o);
  COV_IRQ_LED: cover property (@(posedge clock) run && ind2.sel == IPSEL_FN_IRQ && irq_pending);

endmodule : ipsel_top
`default_nettype wire

// >>> ipsel_defines.svh
// Constants for the indicator, interrupt and reference clock pin selector
`ifndef IPSEL_DEFINES_SVH
`define IPSEL_DEFINES_SVH

`define IPSEL_CLK_HZ 100000000
`define IPSEL_REF_CLK_HZ 50000000
`define IPSEL_REF_HALF_CYC (`IPSEL_CLK_HZ / (2 * `IPSEL_REF_CLK_HZ))
`define IPSEL_REF_CNT_W 4
`define IPSEL_FSEL_W 2
`define IPSEL_STRAP_IRQ 1'b1
`define IPSEL_RST_SYNC 2'h0
`define IPSEL_RST_PIN 1'b0
`define IPSEL_RST_IRQ_N 1'b1

`endif

// >>> ipsel_pkg.sv
// Types for the indicator, interrupt and reference clock pin selector
package ipsel_pkg;

  typedef enum logic [1:0] {
    IPSEL_FN_ACTIVITY,
    IPSEL_FN_SPEED,
    IPSEL_FN_IRQ,
    IPSEL_FN_WAKE
  } ipsel_fn_t;

endpackage : ipsel_pkg

// >>> ipsel_ind_if.sv
// Carrier between the top and one indicator pin selector
`timescale 1ns/1ps
`default_nettype none
interface ipsel_ind_if;
  import ipsel_pkg::*;
  ipsel_fn_t sel;
  logic act;
  logic spd;
  logic irq_n;
  logic wake_n;
  logic pin;
  modport mux (input sel, input act, input spd, input irq_n, input wake_n, output pin);
  modport top (output sel, output act, output spd, output irq_n, output wake_n, input pin);
endinterface : ipsel_ind_if
`default_nettype wire

// >>> ipsel_ind_mux.sv
// One indicator pin: picks its function and registers the pin level
`timescale 1ns/1ps
`default_nettype none
`include "ipsel_defines.svh"
module ipsel_ind_mux
  import ipsel_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  ipsel_ind_if.mux ind
);

  logic pin_q;
  logic pin_d;

  always_comb begin
    pin_d = pin_q;
    if (clk_en) begin
      case (ind.sel)
        IPSEL_FN_ACTIVITY: pin_d = ind.act;
        IPSEL_FN_SPEED: pin_d = ind.spd;
        IPSEL_FN_IRQ: pin_d = ind.irq_n;
        IPSEL_FN_WAKE: pin_d = ind.wake_n;
        default: pin_d = ind.act;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_q <= `IPSEL_RST_PIN;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign ind.pin = pin_q;

endmodule : ipsel_ind_mux
`default_nettype wire

// >>> ipsel_host_model.sv
// Host side model: pulled-up shared wire and external reset driver
`timescale 1ns/1ps
`default_nettype none
module ipsel_host_model (
  input wire logic shared_pin_o,
  input wire logic shared_pin_oe,
  input wire logic reset_req,
  output logic shared_wire,
  output logic ext_reset_n
);
  // Released wire sits at the pull-up level
  assign shared_wire = shared_pin_oe ? shared_pin_o : 1'b1;
  // Reset is requested by holding the pin low
  assign ext_reset_n = ~reset_req;
endmodule : ipsel_host_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the pin selector
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ipsel_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic reset_req = 1'b0;
  logic strap = 1'b1;
  logic act = 1'b0;
  logic spd = 1'b0;
  logic irq = 1'b0;
  logic wake = 1'b0;
  logic [1:0] fsel1 = 2'h0;
  logic [1:0] fsel2 = 2'h0;
  logic ext_reset_n, shared_wire, prev;
  logic first_indicator_pin, second_indicator_pin, irq_n_out, wake_event_n_out;
  logic shared_pin_o, shared_pin_oe, strap_irq_mode, sys_reset_active;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  ipsel_top i_ipsel_top (.clock(clock), .srst(srst), .clk_en(clk_en),
    .ext_reset_n(ext_reset_n), .irq_or_clock_pin_strap(strap),
    .link_activity(act), .link_speed(spd), .irq_pending(irq), .wake_event(wake),
    .first_pin_fsel(fsel1), .second_pin_fsel(fsel2),
    .first_indicator_pin(first_indicator_pin), .second_indicator_pin(second_indicator_pin),
    .irq_n_out(irq_n_out), .wake_event_n_out(wake_event_n_out),
    .shared_pin_o(shared_pin_o), .shared_pin_oe(shared_pin_oe),
    .strap_irq_mode(strap_irq_mode), .sys_reset_active(sys_reset_active));

  ipsel_host_model i_ipsel_host_model (.shared_pin_o(shared_pin_o),
    .shared_pin_oe(shared_pin_oe), .reset_req(reset_req),
    .shared_wire(shared_wire), .ext_reset_n(ext_reset_n));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask : check

  function automatic logic ind_exp(input logic [1:0] f);
    case (f)
      2'h0: ind_exp = act;
      2'h1: ind_exp = spd;
      2'h2: ind_exp = ~irq;
      default: ind_exp = ~wake;
    endcase
  endfunction : ind_exp

  // Reset by power-on or by the external pin, then wait for release
  task automatic sys_reset(input logic s, input logic por);
    int n;
    strap = s;
    if (por)
      srst = 1'b1;
    else
      reset_req = 1'b1;
    repeat (8) @(negedge clock);
    check(sys_reset_active, 1'b1);
    check(irq_n_out, 1'b1);
    check(shared_pin_oe, 1'b0);
    srst = 1'b0;
    reset_req = 1'b0;
    n = 0;
    while (sys_reset_active !== 1'b0 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check(sys_reset_active, 1'b0);
    check(strap_irq_mode, s);
  endtask : sys_reset

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    sys_reset(1'b1, 1'b1);
    $display("test power-on reset done");
    for (int p = 0; p < 2; p++) begin
      for (int f = 0; f < 4; f++) begin
        act = ~p[0];
        spd = p[0];
        irq = p[0];
        wake = ~p[0];
        fsel1 = f[1:0];
        fsel2 = 2'h3 - f[1:0];
        @(negedge clock);
        check(first_indicator_pin, ind_exp(fsel1));
        check(second_indicator_pin, ind_exp(fsel2));
        check(irq_n_out, ~irq);
        check(wake_event_n_out, ~wake);
        check(shared_wire, ~(irq && fsel1 != 2'h2 && fsel2 != 2'h2));
        check(shared_pin_o & shared_pin_oe, 1'b0);
      end
    end
    $display("test function select done");
    clk_en = 1'b0;
    irq = ~irq;
    strap = 1'b0;
    repeat (2) @(negedge clock);
    check(irq_n_out, irq);
    clk_en = 1'b1;
    repeat (3) @(negedge clock);
    check(irq_n_out, ~irq);
    check(strap_irq_mode, 1'b1);
    $display("test enable and strap hold done");
    irq = 1'b1;
    sys_reset(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      prev = shared_pin_o;
      @(negedge clock);
      check(shared_pin_o, ~prev);
      check(shared_pin_oe, 1'b1);
      check(irq_n_out, 1'b0);
    end
    $display("test reference clock done");
    sys_reset(1'b1, 1'b0);
    sys_reset(1'b0, 1'b1);
    sys_reset(1'b1, 1'b1);
    @(negedge clock);
    check(shared_wire, 1'b0);
    $display("test strap relatch done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
